//--- hdl/lsm_params.svh
// Constants for the load/store memory access block: offsets, fields, codes.
// Assumes one core clock and inclusion by every design file that needs them.
`ifndef LSM_PARAMS_SVH
`define LSM_PARAMS_SVH
`define LSM_ELEM_BYTES 8
`define LSM_SIZE_BYTE 3'h0
`define LSM_SIZE_WORD 3'h3
`define LSM_SIZE_DOUBLE 3'h7
`define LSM_ADDR_CTRL 8'h00
`define LSM_ADDR_STATUS 8'h04
`define LSM_ADDR_FAULT 8'h08
`define LSM_ADDR_MAP 8'h10
`define LSM_CTRL_BIG_ENDIAN 0
`define LSM_STATUS_BUSY 16
`define LSM_UNMAP_SEG 2'h2
`define LSM_UNMAP_UNCACHED_BIT 29
`define LSM_CCA_UNCACHED 3'h2
`define LSM_CCA_CACHED 3'h3
`define LSM_MAP_VALID 0
`define LSM_MAP_WRITE 1
`define LSM_MAP_EXEC 2
`define LSM_SYS_COPRO 2'h0
`endif

//--- hdl/lsm_pkg.sv
// Types shared by the load/store memory access block.
// Assumes lsm_params.svh is visible for the numeric constants.
package lsm_pkg;
	typedef enum logic [2:0] {
		LSM_OP_LOAD, LSM_OP_STORE, LSM_OP_COPRO_WORD_LOAD, LSM_OP_COPRO_DOUBLE_LOAD,
		LSM_OP_COPRO_WORD_STORE, LSM_OP_COPRO_DOUBLE_STORE, LSM_OP_COPRO_FUNCTION_ISSUE
	} lsm_op_t;
	typedef enum logic [2:0] {
		LSM_EXC_NONE, LSM_EXC_MAP_MISS, LSM_EXC_PROTECT, LSM_EXC_ALIGN, LSM_EXC_COPRO
	} lsm_exc_t;
	// Request from the core; store values are right-justified.
	typedef struct packed {
		lsm_op_t op;
		logic [31:0] virtual_addr;
		logic [2:0] access_size_code;
		logic fetch_or_data_sel;
		logic [63:0] sdata;
		logic [1:0] unit;
		logic [4:0] copro_reg_spec;
		logic [24:0] func;
	} lsm_core_req_t;
	// Request to caches and memory; data and mask sit in element lanes.
	typedef struct packed {
		logic [31:0] paddr;
		logic [2:0] access_size_code;
		logic [2:0] cache_coherency_attr;
		logic write;
		logic fetch_or_data_sel;
		logic [7:0] mask;
		logic [63:0] aligned_element;
	} lsm_mem_req_t;
	// Message to a numbered coprocessor.
	typedef struct packed {
		lsm_op_t op;
		logic [1:0] unit;
		logic [4:0] copro_reg_spec;
		logic [63:0] data;
		logic [24:0] func;
	} lsm_copro_msg_t;
endpackage : lsm_pkg

//--- hdl/lsm_lanes.sv
// Byte-lane steering inside one naturally aligned 64-bit element.
// Assumes a pure combinational use; the caller registers every result.
`include "lsm_params.svh"
module lsm_lanes import lsm_pkg::*; (
	// Access shape.
	input wire logic [2:0] i_size,
	input wire logic [2:0] i_off,
	input wire logic i_big_endian,
	// Data in both directions.
	input wire logic [63:0] i_elem,
	input wire logic [63:0] i_value,
	// Results.
	output logic [7:0] o_mask,
	output logic [63:0] o_value,
	output logic [63:0] o_elem,
	output logic o_misalign
);
	// Lowest lane that the object occupies in the element.
	function automatic logic [2:0] lane_base(input logic [2:0] size, input logic [2:0] off, input logic be);
		lane_base = be ? 3'(3'h7 - off - size) : off;
	endfunction : lane_base

	logic [2:0] base;
	logic [63:0] width_bits;
	logic [5:0] shift_bits;

	// Object address is the lowest byte, so it must not run past the element end.
	assign o_misalign = ({1'b0, i_off} + {1'b0, i_size}) > 4'(`LSM_SIZE_DOUBLE);
	assign base = lane_base(i_size, i_off, i_big_endian);
	assign shift_bits = {base, 3'h0};
	// Size code plus one bytes are active, starting at the base lane.
	assign o_mask = 8'((8'hff >> (3'h7 - i_size)) << base);
	assign width_bits = 64'hffff_ffff_ffff_ffff >> {3'h7 - i_size, 3'h0};
	assign o_value = (i_elem >> shift_bits) & width_bits;
	// Lanes outside the mask carry zero, though memory must ignore them anyway.
	assign o_elem = (i_value & width_bits) << shift_bits;
endmodule : lsm_lanes

//--- hdl/lsm_xlate.sv
// Virtual-to-physical translation with a small software-loaded mapping table.
// Assumes table writes come from the register port of the same clock.
`include "lsm_params.svh"
module lsm_xlate import lsm_pkg::*; #(
	parameter int MAP_N = 4
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Table write and readback.
	input wire logic i_map_we,
	input wire logic [$clog2(MAP_N)-1:0] i_map_idx,
	input wire logic [31:0] i_map_wdata,
	output logic [31:0] o_map_rdata,
	// Lookup.
	input wire logic [31:0] i_virtual_addr,
	input wire logic i_fetch_or_data_sel,
	input wire logic i_read_or_write_sel,
	output logic [31:0] o_paddr,
	output logic [2:0] o_cca,
	output lsm_exc_t o_fault
);
	// Entry: [31:20] virtual page, [19:8] physical page, [6:4] attribute, exec, write, valid.
	logic [31:0] map_ff [MAP_N];

	// Table is cleared so that mapped space faults until software fills it.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < MAP_N; i++) map_ff[i] <= 32'h0000_0000;
		end else if (i_map_we) begin
			map_ff[i_map_idx] <= i_map_wdata;
		end
	end
	assign o_map_rdata = map_ff[i_map_idx];

	// Unmapped segment bypasses the table; otherwise the last matching entry wins.
	always_comb begin
		o_paddr = 32'h0000_0000;
		o_cca = `LSM_CCA_UNCACHED;
		o_fault = LSM_EXC_MAP_MISS;
		if (i_virtual_addr[31:30] == `LSM_UNMAP_SEG) begin
			o_paddr = {3'h0, i_virtual_addr[28:0]};
			o_cca = i_virtual_addr[`LSM_UNMAP_UNCACHED_BIT] ? `LSM_CCA_UNCACHED : `LSM_CCA_CACHED;
			o_fault = LSM_EXC_NONE;
		end else begin
			for (int i = 0; i < MAP_N; i++) begin
				if (map_ff[i][`LSM_MAP_VALID] && map_ff[i][31:20] == i_virtual_addr[31:20]) begin
					o_paddr = {map_ff[i][19:8], i_virtual_addr[19:0]};
					o_cca = map_ff[i][6:4];
					if ((i_read_or_write_sel && !map_ff[i][`LSM_MAP_WRITE]) ||
						(i_fetch_or_data_sel && !map_ff[i][`LSM_MAP_EXEC])) begin
						o_fault = LSM_EXC_PROTECT;
					end else begin
						o_fault = LSM_EXC_NONE;
					end
				end
			end
		end
	end
endmodule : lsm_xlate

//--- hdl/lsm_access.sv
// Load/store access path: translation, lane steering, memory and coprocessor exchange.
// Assumes a cache/memory slave with valid/ready requests and one rvalid per load.
//
// The register addresses and the plain strobed port were decided locally.
`include "lsm_params.svh"
module lsm_access import lsm_pkg::*; #(
	parameter int MAP_N = 4
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port.
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [31:0] o_reg_rdata,
	// Core request and answers.
	input wire logic i_req_valid,
	input wire lsm_core_req_t i_req,
	output logic o_req_ready,
	output logic o_ld_valid,
	output logic [63:0] o_ld_data,
	output logic [7:0] o_ld_bytes,
	output logic o_st_done,
	output logic o_exc_valid,
	output lsm_exc_t o_exc_code,
	// Memory hierarchy.
	output logic o_mem_valid,
	output lsm_mem_req_t o_mem_req,
	input wire logic i_mem_ready,
	input wire logic i_mem_rvalid,
	input wire logic [63:0] i_mem_rdata,
	// Coprocessors.
	output logic o_cop_valid,
	output lsm_copro_msg_t o_cop,
	input wire logic i_cop_svalid,
	input wire logic [63:0] i_cop_sdata
);
	// Idle takes a request; check translates and tests for faults.
	// Cget waits for coprocessor store data; mreq holds the memory request.
	// Mrsp waits for load data. One access at a time keeps ordering simple,
	// at the cost of throughput.
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_CGET, ST_MREQ, ST_MRSP} lsm_state_t;

	lsm_state_t state_ff;
	lsm_state_t nxt_state;
	lsm_core_req_t req_ff;
	lsm_mem_req_t mem_ff;
	lsm_copro_msg_t cop_ff;
	logic cop_pulse_ff;
	logic ld_valid_ff;
	logic [63:0] ld_data_ff;
	logic [7:0] ld_bytes_ff;
	logic st_done_ff;
	logic exc_valid_ff;
	lsm_exc_t exc_code_ff;
	logic big_endian_ff;
	logic [15:0] fault_cnt_ff;
	logic [31:0] fault_addr_ff;
	logic [31:0] reg_rdata_ff;
	logic [31:0] map_rdata;
	logic map_we;
	logic [31:0] xl_paddr;
	logic [2:0] xl_cca;
	lsm_exc_t xl_fault;
	logic is_store;
	logic is_load;
	logic is_exchange;
	logic [2:0] eff_size;
	logic [7:0] ln_mask;
	logic [63:0] ln_value;
	logic [63:0] ln_elem;
	logic ln_misalign;
	logic [63:0] st_value;
	lsm_exc_t check_exc;

	// Decode of the latched request.
	function automatic logic op_is_store(input lsm_op_t op);
		op_is_store = op == LSM_OP_STORE || op == LSM_OP_COPRO_WORD_STORE || op == LSM_OP_COPRO_DOUBLE_STORE;
	endfunction : op_is_store

	function automatic logic op_is_copro_store(input lsm_op_t op);
		op_is_copro_store = op == LSM_OP_COPRO_WORD_STORE || op == LSM_OP_COPRO_DOUBLE_STORE;
	endfunction : op_is_copro_store

	// Map slots are whole words from the map base upward.
	function automatic logic addr_in_map(input logic [7:0] addr);
		addr_in_map = addr >= `LSM_ADDR_MAP && addr < 8'(`LSM_ADDR_MAP + 4 * MAP_N) && addr[1:0] == 2'h0;
	endfunction : addr_in_map

	assign is_store = op_is_store(req_ff.op);
	assign is_load = !is_store && req_ff.op != LSM_OP_COPRO_FUNCTION_ISSUE;
	assign is_exchange = req_ff.op != LSM_OP_LOAD && req_ff.op != LSM_OP_STORE &&
		req_ff.op != LSM_OP_COPRO_FUNCTION_ISSUE;

	// Coprocessor exchanges have a fixed size; plain accesses use the core's code.
	// This keeps the element check valid for any core size.
	always_comb begin
		case (req_ff.op)
			LSM_OP_COPRO_WORD_LOAD, LSM_OP_COPRO_WORD_STORE: eff_size = `LSM_SIZE_WORD;
			LSM_OP_COPRO_DOUBLE_LOAD, LSM_OP_COPRO_DOUBLE_STORE: eff_size = `LSM_SIZE_DOUBLE;
			default: eff_size = req_ff.access_size_code;
		endcase
	end

	// Translation of the latched virtual address.
	// The table is read combinationally, so it adds no wait.
	lsm_xlate #(.MAP_N(MAP_N)) u_xlate (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_map_we(map_we),
		.i_map_idx(i_reg_addr[$clog2(MAP_N)+1:2]),
		.i_map_wdata(i_reg_wdata),
		.o_map_rdata(map_rdata),
		.i_virtual_addr(req_ff.virtual_addr),
		.i_fetch_or_data_sel(req_ff.fetch_or_data_sel),
		.i_read_or_write_sel(is_store),
		.o_paddr(xl_paddr),
		.o_cca(xl_cca),
		.o_fault(xl_fault)
	);

	// Store value comes from the core or, for exchanges, from the coprocessor.
	// Coprocessor data is used as it arrives: the memory request is built on that edge.
	always_comb begin
		if (state_ff == ST_CGET && req_ff.op == LSM_OP_COPRO_WORD_STORE) begin
			st_value = {32'h0000_0000, i_cop_sdata[31:0]};
		end else if (state_ff == ST_CGET) begin
			st_value = i_cop_sdata;
		end else begin
			st_value = req_ff.sdata;
		end
	end

	// Lanes for both directions; memory data in, store value out.
	// One steering unit serves loads and stores alike.
	lsm_lanes u_lanes (
		.i_size(eff_size),
		.i_off(req_ff.virtual_addr[2:0]),
		.i_big_endian(big_endian_ff),
		.i_elem(i_mem_rdata),
		.i_value(st_value),
		.o_mask(ln_mask),
		.o_value(ln_value),
		.o_elem(ln_elem),
		.o_misalign(ln_misalign)
	);

	// Fault priority: coprocessor choice, then alignment, then translation.
	// Any fault sends the sequencer home before memory is touched.
	always_comb begin
		check_exc = LSM_EXC_NONE;
		if (req_ff.op != LSM_OP_LOAD && req_ff.op != LSM_OP_STORE && req_ff.unit == `LSM_SYS_COPRO) begin
			check_exc = LSM_EXC_COPRO;
		end else if (req_ff.op != LSM_OP_COPRO_FUNCTION_ISSUE) begin
			if (ln_misalign) begin
				check_exc = LSM_EXC_ALIGN;
			end else begin
				check_exc = xl_fault;
			end
		end
	end

	// Sequencer: each step waits for the one before it.
	// Steps run in a fixed order, so effects keep their order.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: if (i_req_valid) nxt_state = ST_CHECK;
			ST_CHECK: begin
				if (check_exc != LSM_EXC_NONE || req_ff.op == LSM_OP_COPRO_FUNCTION_ISSUE) begin
					nxt_state = ST_IDLE;
				end else if (op_is_copro_store(req_ff.op)) begin
					nxt_state = ST_CGET;
				end else begin
					nxt_state = ST_MREQ;
				end
			end
			ST_CGET: if (i_cop_svalid) nxt_state = ST_MREQ;
			ST_MREQ: if (i_mem_ready) nxt_state = is_load ? ST_MRSP : ST_IDLE;
			ST_MRSP: if (i_mem_rvalid) nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) state_ff <= ST_IDLE;
		else state_ff <= nxt_state;
	end

	// Core request is taken only while idle; coprocessor store data replaces sdata.
	// The copy keeps the request whole for later steps.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			req_ff <= '0;
		end else if (state_ff == ST_IDLE && i_req_valid) begin
			req_ff <= i_req;
		end else if (state_ff == ST_CGET && i_cop_svalid) begin
			if (req_ff.op == LSM_OP_COPRO_WORD_STORE) begin
				req_ff.sdata <= {32'h0000_0000, i_cop_sdata[31:0]};
			end else begin
				req_ff.sdata <= i_cop_sdata;
			end
		end
	end

	// Memory request is built once the element, mask and attribute are known.
	// Cached loads ask for the whole element, so a miss fills at least that.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_ff <= '0;
		end else if (nxt_state == ST_MREQ && state_ff != ST_MREQ) begin
			mem_ff.paddr <= xl_paddr;
			mem_ff.access_size_code <= eff_size;
			mem_ff.cache_coherency_attr <= xl_cca;
			mem_ff.write <= is_store;
			mem_ff.fetch_or_data_sel <= req_ff.fetch_or_data_sel;
			if (is_store) begin
				mem_ff.mask <= ln_mask;
			end else if (xl_cca == `LSM_CCA_UNCACHED) begin
				mem_ff.mask <= ln_mask;
			end else begin
				mem_ff.mask <= 8'hff;
			end
			mem_ff.aligned_element <= ln_elem;
		end
	end

	// Uncached loads mark only the referenced lanes; cached loads fill the element.
	assign o_mem_valid = state_ff == ST_MREQ;
	assign o_mem_req = mem_ff;

	// Load answers go to the core or, for exchanges, to the coprocessor.
	// Data and mask hold until the next load, so the core may read late.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ld_valid_ff <= 1'b0;
			ld_data_ff <= 64'h0000_0000_0000_0000;
			ld_bytes_ff <= 8'h00;
		end else begin
			ld_valid_ff <= state_ff == ST_MRSP && i_mem_rvalid && !is_exchange;
			if (state_ff == ST_MRSP && i_mem_rvalid) begin
				ld_data_ff <= ln_value;
				ld_bytes_ff <= mem_ff.mask;
			end
		end
	end

	// Coprocessor messages: load data, store requests and function issue.
	// Unit zero never gets here, as the check stage faults it.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cop_ff <= '0;
			cop_pulse_ff <= 1'b0;
		end else begin
			cop_pulse_ff <= 1'b0;
			if (state_ff == ST_CHECK && check_exc == LSM_EXC_NONE) begin
				cop_ff.op <= req_ff.op;
				cop_ff.unit <= req_ff.unit;
				cop_ff.copro_reg_spec <= req_ff.copro_reg_spec;
				cop_ff.data <= 64'h0000_0000_0000_0000;
				cop_ff.func <= req_ff.func;
				cop_pulse_ff <= req_ff.op == LSM_OP_COPRO_FUNCTION_ISSUE;
			end else if (state_ff == ST_MRSP && i_mem_rvalid && is_exchange) begin
				if (req_ff.op == LSM_OP_COPRO_WORD_LOAD) begin
					cop_ff.data <= {32'h0000_0000, ln_value[31:0]};
				end else begin
					cop_ff.data <= ln_value;
				end
				cop_pulse_ff <= 1'b1;
			end
		end
	end

	// A store request holds valid until the coprocessor answers with its data.
	// A coprocessor that never answers stalls the block.
	assign o_cop_valid = cop_pulse_ff || state_ff == ST_CGET;
	assign o_cop = cop_ff;

	// Completion and exception pulses.
	// Each pulse lasts exactly one cycle.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_done_ff <= 1'b0;
			exc_valid_ff <= 1'b0;
			exc_code_ff <= LSM_EXC_NONE;
		end else begin
			st_done_ff <= state_ff == ST_MREQ && i_mem_ready && is_store;
			exc_valid_ff <= state_ff == ST_CHECK && check_exc != LSM_EXC_NONE;
			if (state_ff == ST_CHECK) exc_code_ff <= check_exc;
		end
	end

	assign o_req_ready = state_ff == ST_IDLE;
	assign o_ld_valid = ld_valid_ff;
	assign o_ld_data = ld_data_ff;
	assign o_ld_bytes = ld_bytes_ff;
	assign o_st_done = st_done_ff;
	assign o_exc_valid = exc_valid_ff;
	assign o_exc_code = exc_code_ff;

	// Control register; the endian bit steers lane selection.
	// Change it only while idle, or one access may mix orders.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) big_endian_ff <= 1'b0;
		else if (i_reg_write && i_reg_addr == `LSM_ADDR_CTRL) big_endian_ff <= i_reg_wdata[`LSM_CTRL_BIG_ENDIAN];
	end

	// Fault history; the counter saturates so software never sees it wrap.
	// A fault beside a clear wins, so no fault is lost.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fault_cnt_ff <= 16'h0000;
			fault_addr_ff <= 32'h0000_0000;
		end else if (state_ff == ST_CHECK && check_exc != LSM_EXC_NONE) begin
			if (fault_cnt_ff != 16'hffff) fault_cnt_ff <= fault_cnt_ff + 16'h0001;
			fault_addr_ff <= req_ff.virtual_addr;
		end else if (i_reg_write && i_reg_addr == `LSM_ADDR_STATUS) begin
			fault_cnt_ff <= 16'h0000;
		end
	end

	// Table writes land only on whole-word slot addresses.
	assign map_we = i_reg_write && addr_in_map(i_reg_addr);

	// Read data stands for the one cycle after the strobe; unmapped reads give zero.
	// Zero outside that cycle keeps a shared read bus clean.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			reg_rdata_ff <= 32'h0000_0000;
		end else if (i_reg_read) begin
			if (i_reg_addr == `LSM_ADDR_CTRL) reg_rdata_ff <= {31'h0, big_endian_ff};
			else if (i_reg_addr == `LSM_ADDR_STATUS) reg_rdata_ff <= {15'h0, state_ff != ST_IDLE, fault_cnt_ff};
			else if (i_reg_addr == `LSM_ADDR_FAULT) reg_rdata_ff <= fault_addr_ff;
			else if (addr_in_map(i_reg_addr)) reg_rdata_ff <= map_rdata;
			else reg_rdata_ff <= 32'h0000_0000;
		end else begin
			reg_rdata_ff <= 32'h0000_0000;
		end
	end
	assign o_reg_rdata = reg_rdata_ff;
endmodule : lsm_access

//--- sim/lsm_access_chk.sv
// Port-level checks for the load/store access block.
// Assumes a bind onto lsm_access; one clock, asynchronous active-high reset.
`include "lsm_params.svh"
module lsm_access_chk import lsm_pkg::*; #(
	parameter int MAP_N = 4
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Core side.
	input wire logic i_req_valid,
	input wire lsm_core_req_t i_req,
	input wire logic o_req_ready,
	input wire logic o_ld_valid,
	input wire logic o_st_done,
	input wire logic o_exc_valid,
	// Memory and coprocessor side.
	input wire logic o_mem_valid,
	input wire lsm_mem_req_t o_mem_req,
	input wire logic i_mem_ready,
	input wire logic i_mem_rvalid,
	input wire logic o_cop_valid,
	input wire lsm_copro_msg_t o_cop
);
	timeunit 1ns;
	timeprecision 1ns;
	// All checks share the core clock and stay quiet while reset is held.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_take_busy: assert property (i_req_valid && o_req_ready |=> !o_req_ready)
		else $error("ready stayed high after a request was taken");
	a_mem_hold: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_req))
		else $error("memory request changed before it was accepted");
	a_exc_time: assert property (o_exc_valid |-> $past(i_req_valid && o_req_ready, 2))
		else $error("exception not two cycles after its request");
	a_exc_no_mem: assert property (o_exc_valid |-> !o_mem_valid ##1 !o_mem_valid)
		else $error("memory request beside a fault");
	a_st_done: assert property (o_st_done |-> $past(o_mem_valid && i_mem_ready && o_mem_req.write))
		else $error("store done without an accepted write");
	a_ld_after: assert property (o_ld_valid |-> $past(i_mem_rvalid))
		else $error("load answer without memory data");
	// Stores and uncached loads touch as many bytes as the size code plus one.
	a_lane_count: assert property (o_mem_valid && (o_mem_req.write ||
		o_mem_req.cache_coherency_attr == `LSM_CCA_UNCACHED) |->
		$countones(o_mem_req.mask) == o_mem_req.access_size_code + 1)
		else $error("lane mask count differs from size code plus one");
	a_full_elem: assert property (o_mem_valid && !o_mem_req.write &&
		o_mem_req.cache_coherency_attr == `LSM_CCA_CACHED |-> o_mem_req.mask == 8'hff)
		else $error("cached load does not cover the whole element");
	a_func_pass: assert property (i_req_valid && o_req_ready && i_req.op == LSM_OP_COPRO_FUNCTION_ISSUE &&
		i_req.unit != `LSM_SYS_COPRO |-> ##2 o_cop_valid && o_cop.func == $past(i_req.func, 2) &&
		o_cop.unit == $past(i_req.unit, 2))
		else $error("function field not passed to the coprocessor");
endmodule : lsm_access_chk

//--- sim/lsm_mem_model.sv
// Partner model: memory slave plus the numbered coprocessors.
// Assumes requests hold until ready; slow mode stalls ready three cycles.
module lsm_mem_model import lsm_pkg::*; (
	// Clock, reset and pacing.
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_slow,
	// Memory slave.
	input wire logic i_valid,
	input wire lsm_mem_req_t i_req,
	output logic o_ready,
	output logic o_rvalid,
	output logic [63:0] o_rdata,
	// Coprocessor store source.
	input wire logic i_cop_valid,
	input wire lsm_copro_msg_t i_cop,
	output logic o_svalid,
	output logic [63:0] o_sdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] mem [8];
	logic [63:0] rbuf;
	logic [1:0] wait_ff;
	logic pend_ff;
	// Unrequested lanes come back inverted, so a design trusting them sees junk.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ready <= 1'b0;
			o_rvalid <= 1'b0;
			pend_ff <= 1'b0;
			wait_ff <= 2'h0;
			o_rdata <= '0;
		end else begin
			wait_ff <= (i_valid && !o_ready) ? wait_ff + 2'h1 : 2'h0;
			o_ready <= i_valid && !o_ready && (!i_slow || wait_ff == 2'h3);
			pend_ff <= i_valid && o_ready && !i_req.write;
			o_rvalid <= pend_ff;
			o_rdata <= pend_ff ? rbuf : ~o_rdata;
			for (int i = 0; i < 8; i++) begin
				if (i_valid && o_ready && i_req.write && i_req.mask[i])
					mem[i_req.paddr[5:3]][i*8+:8] <= i_req.aligned_element[i*8+:8];
				rbuf[i*8+:8] <= i_req.mask[i] ? mem[i_req.paddr[5:3]][i*8+:8] : ~mem[i_req.paddr[5:3]][i*8+:8];
			end
		end
	end
	// A store fetch is answered once; a word fetch carries junk above its low word.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_svalid <= 1'b0;
			o_sdata <= '0;
		end else begin
			o_svalid <= i_cop_valid && !o_svalid && (i_cop.op == LSM_OP_COPRO_WORD_STORE ||
				i_cop.op == LSM_OP_COPRO_DOUBLE_STORE);
			o_sdata <= o_svalid ? ~o_sdata : {16'hFACE, 14'h0, i_cop.unit, 16'hBEEF, 11'h0, i_cop.copro_reg_spec};
		end
	end
endmodule : lsm_mem_model

//--- sim/lsm_access_tb.sv
// Self-checking bench for lsm_access: register port, core requests, partner model.
// Assumes the design files and lsm_pkg are compiled first.
`include "lsm_params.svh"
module lsm_access_tb import lsm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_rst = 1, i_reg_write = 0, i_reg_read = 0, i_req_valid = 0, slow = 0, fetch = 0;
	logic [7:0] i_reg_addr = '0, o_ld_bytes;
	logic [31:0] i_reg_wdata = '0, o_reg_rdata;
	logic o_req_ready, o_ld_valid, o_st_done, o_exc_valid, o_mem_valid, i_mem_ready, i_mem_rvalid;
	logic o_cop_valid, i_cop_svalid;
	logic [63:0] o_ld_data, i_mem_rdata, i_cop_sdata;
	lsm_core_req_t i_req = '0;
	lsm_mem_req_t o_mem_req, mreq;
	lsm_copro_msg_t o_cop, cmsg;
	lsm_exc_t o_exc_code;
	int failures = 0, n_compared = 0, n_ans = 0, n_mem = 0, cyc = 0, m0;
	lsm_access #(.MAP_N(4)) dut_u (.i_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read,
		.o_reg_rdata, .i_req_valid, .i_req, .o_req_ready, .o_ld_valid, .o_ld_data, .o_ld_bytes, .o_st_done,
		.o_exc_valid, .o_exc_code, .o_mem_valid, .o_mem_req, .i_mem_ready, .i_mem_rvalid, .i_mem_rdata,
		.o_cop_valid, .o_cop, .i_cop_svalid, .i_cop_sdata);
	lsm_mem_model mem_u (.i_clk, .i_rst, .i_slow(slow), .i_valid(o_mem_valid), .i_req(o_mem_req),
		.o_ready(i_mem_ready), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata), .i_cop_valid(o_cop_valid),
		.i_cop(o_cop), .o_svalid(i_cop_svalid), .o_sdata(i_cop_sdata));
	// Core clock, 20 ns period.
	always #10 i_clk = ~i_clk;
	// Counts answers and accepted memory requests; also cuts a hang short.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			failures++;
			summarize();
		end
		if (o_ld_valid || o_st_done || o_exc_valid || (o_cop_valid && o_cop.op != LSM_OP_COPRO_WORD_STORE &&
			o_cop.op != LSM_OP_COPRO_DOUBLE_STORE))
			n_ans <= n_ans + 1;
		if (o_cop_valid)
			cmsg <= o_cop;
		if (o_mem_valid && i_mem_ready) begin
			mreq <= o_mem_req;
			n_mem <= n_mem + 1;
		end
	end
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_reg_addr <= a;
		i_reg_wdata <= v;
		i_reg_write <= 1'b1;
		@(posedge i_clk);
		i_reg_write <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_reg_addr <= a;
		i_reg_read <= 1'b1;
		@(posedge i_clk);
		i_reg_read <= 1'b0;
		@(posedge i_clk);
		chk("reg", 64'(e), 64'(o_reg_rdata));
	endtask : rd
	// One core request, held until taken, then a bounded wait for its answer.
	task automatic go(input lsm_op_t op, input logic [31:0] va, input logic [2:0] sz, input logic [63:0] sd,
		input logic [1:0] un);
		int k, n;
		k = n_ans;
		n = 0;
		i_req_valid <= 1'b1;
		i_req <= '{op, va, sz, fetch, sd, un, 5'h11, 25'h1AB_CDEF};
		do @(posedge i_clk); while (o_req_ready !== 1'b1);
		i_req_valid <= 1'b0;
		while (n_ans == k && n < 100) begin
			@(posedge i_clk);
			n++;
		end
		chk("answer", 64'h1, 64'(n < 100));
	endtask : go
	task automatic summarize();
		if (failures == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	// Main sequence.
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk("ready", 64'h1, 64'(o_req_ready));
		rd(`LSM_ADDR_CTRL, 32'h0);
		rd(8'h0C, 32'h0);
		go(LSM_OP_STORE, 32'hA000_0008, 3'h7, 64'h0807_0605_0403_0201, 2'h0);
		chk("paddr", 64'h8, 64'(mreq.paddr));
		chk("cca", 64'(`LSM_CCA_UNCACHED), 64'(mreq.cache_coherency_attr));
		go(LSM_OP_STORE, 32'hA000_000B, 3'h0, 64'hEE, 2'h0);
		chk("mask", 64'h08, 64'(mreq.mask));
		chk("lane", 64'hEE, 64'(mreq.aligned_element[31:24]));
		slow <= 1'b1;
		go(LSM_OP_LOAD, 32'hA000_000C, 3'h3, 64'h0, 2'h0);
		chk("ld", 64'h0807_0605, o_ld_data);
		chk("bytes", 64'hF0, 64'(o_ld_bytes));
		chk("mask", 64'hF0, 64'(mreq.mask));
		go(LSM_OP_LOAD, 32'h8000_0008, 3'h1, 64'h0, 2'h0);
		chk("ld", 64'h0201, o_ld_data);
		chk("mask", 64'hFF, 64'(mreq.mask));
		wr(`LSM_ADDR_CTRL, 32'h1);
		go(LSM_OP_LOAD, 32'hA000_0008, 3'h0, 64'h0, 2'h0);
		chk("ld", 64'h08, o_ld_data);
		go(LSM_OP_LOAD, 32'hA000_000C, 3'h3, 64'h0, 2'h0);
		chk("ld", 64'hEE03_0201, o_ld_data);
		chk("bytes", 64'h0F, 64'(o_ld_bytes));
		wr(`LSM_ADDR_CTRL, 32'h0);
		m0 = n_mem;
		go(LSM_OP_LOAD, 32'hA000_000E, 3'h3, 64'h0, 2'h0);
		chk("exc", 64'(LSM_EXC_ALIGN), 64'(o_exc_code));
		go(LSM_OP_COPRO_WORD_LOAD, 32'hA000_0008, 3'h3, 64'h0, 2'h0);
		chk("exc", 64'(LSM_EXC_COPRO), 64'(o_exc_code));
		go(LSM_OP_LOAD, 32'h0000_0010, 3'h7, 64'h0, 2'h0);
		chk("exc", 64'(LSM_EXC_MAP_MISS), 64'(o_exc_code));
		chk("memreqs", 64'(m0), 64'(n_mem));
		rd(`LSM_ADDR_FAULT, 32'h10);
		rd(`LSM_ADDR_STATUS, 32'h3);
		wr(`LSM_ADDR_STATUS, 32'h0);
		rd(`LSM_ADDR_STATUS, 32'h0);
		wr(`LSM_ADDR_MAP, 32'h0000_1031);
		rd(`LSM_ADDR_MAP, 32'h0000_1031);
		go(LSM_OP_LOAD, 32'h0000_0010, 3'h7, 64'h0, 2'h0);
		chk("paddr", 64'h0100_0010, 64'(mreq.paddr));
		chk("cca", 64'(`LSM_CCA_CACHED), 64'(mreq.cache_coherency_attr));
		go(LSM_OP_STORE, 32'h0000_0010, 3'h7, 64'h0, 2'h0);
		chk("exc", 64'(LSM_EXC_PROTECT), 64'(o_exc_code));
		fetch = 1'b1;
		go(LSM_OP_LOAD, 32'h0000_0010, 3'h7, 64'h0, 2'h0);
		chk("exc", 64'(LSM_EXC_PROTECT), 64'(o_exc_code));
		go(LSM_OP_LOAD, 32'hA000_0008, 3'h3, 64'h0, 2'h0);
		chk("fetch", 64'h1, 64'(mreq.fetch_or_data_sel));
		chk("ld", 64'hEE03_0201, o_ld_data);
		fetch = 1'b0;
		go(LSM_OP_COPRO_DOUBLE_STORE, 32'hA000_0010, 3'h7, 64'h0, 2'h2);
		chk("elem", 64'hFACE_0002_BEEF_0011, mreq.aligned_element);
		go(LSM_OP_COPRO_WORD_STORE, 32'hA000_0018, 3'h3, 64'h0, 2'h3);
		chk("elem", 64'hBEEF_0011, 64'(mreq.aligned_element[31:0]));
		chk("mask", 64'h0F, 64'(mreq.mask));
		go(LSM_OP_COPRO_WORD_LOAD, 32'hA000_0018, 3'h3, 64'h0, 2'h1);
		chk("cop", 64'hBEEF_0011, 64'(cmsg.data[31:0]));
		chk("copreg", 64'h31, 64'({cmsg.unit, cmsg.copro_reg_spec}));
		go(LSM_OP_COPRO_DOUBLE_LOAD, 32'hA000_0010, 3'h7, 64'h0, 2'h2);
		chk("cop", 64'hFACE_0002_BEEF_0011, cmsg.data);
		go(LSM_OP_COPRO_FUNCTION_ISSUE, 32'h0, 3'h0, 64'h0, 2'h3);
		chk("func", 64'h1AB_CDEF, 64'(cmsg.func));
		summarize();
	end
endmodule : lsm_access_tb
bind lsm_access lsm_access_chk #(.MAP_N(MAP_N)) chk_u (.i_clk, .i_rst, .i_req_valid, .i_req, .o_req_ready,
	.o_ld_valid, .o_st_done, .o_exc_valid, .o_mem_valid, .o_mem_req, .i_mem_ready, .i_mem_rvalid, .o_cop_valid,
	.o_cop);
